//--- rtl/sdac_defs.vh
// Purpose: constants for the sigma-delta converter control block
// Assumes: 50 MHz system clock, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
`ifndef SDAC_DEFS_VH
`define SDAC_DEFS_VH
`define SDAC_AW            4
`define SDAC_REG_CONFIG    4'h0
`define SDAC_REG_MUX       4'h1
`define SDAC_REG_RESULT    4'h2
`define SDAC_REG_STATUS    4'h3
`define SDAC_REG_INT_EN    4'h4
`define SDAC_REG_INT_CLR   4'h5
`define SDAC_REG_OFFSET    4'h6
`define SDAC_REG_GAIN      4'h7
`define SDAC_REG_ROUTE     4'h8
`define SDAC_REG_CMD       4'h9
// config fields
`define SDAC_CFG_RATE_LSB  0
`define SDAC_CFG_GAIN_LSB  3
`define SDAC_CFG_BIPOLAR   5
`define SDAC_CFG_CONT      6
`define SDAC_CFG_SWAP      7
`define SDAC_CFG_REFBUF    8
`define SDAC_CFG_INT_POL   9
`define SDAC_CFG_RESET     16'h0000
// status bits
`define SDAC_ST_READY      0
`define SDAC_ST_RANGE      1
`define SDAC_ST_CALDONE    2
`define SDAC_INT_EN_RESET  3'h1
// command bits
`define SDAC_CMD_START     0
`define SDAC_CMD_ZCAL      1
`define SDAC_CMD_FCAL      2
`define SDAC_CMD_STOP      3
// calibration defaults
`define SDAC_OFFSET_RESET  16'h0000
`define SDAC_GAIN_RESET    16'h8000
// timing
`define SDAC_CLK_HZ        50000000
`define SDAC_SETTLE_PERIODS 3'd4
`define SDAC_NUM_RATES     8
`endif

//--- rtl/sdac_filter.v
// Purpose: decimation-rate timer and digital gain stage of the converter path
// Assumes: raw modulator-filter words arrive as signed 16-bit samples
// Notes: gain is a sign-extended left shift; four guard bits keep x8 exact
`default_nettype none
module sdac_filter #(
  parameter WIDTH = 16
) (
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire             run_in,
  input  wire [31:0]      period_in,
  input  wire [1:0]       gain_in,
  input  wire [WIDTH-1:0] raw_in,
  output reg              tick_out,
  output reg  [WIDTH+3:0] scaled_out
);
  reg [31:0] count;

  always @(posedge clock_in)
  begin
    if (rst_in || !run_in)
    begin
      count      <= 32'h0;
      tick_out   <= 1'b0;
      scaled_out <= {(WIDTH+4){1'b0}};
    end
    else
    begin
      tick_out <= 1'b0;
      if (count >= period_in - 32'h1)
      begin
        count      <= 32'h0;
        tick_out   <= 1'b1;
        // gain applied digitally in the filter output path
        scaled_out <= $signed({{4{raw_in[WIDTH-1]}}, raw_in}) <<< gain_in;
      end
      else
        count <= count + 32'h1;
    end
  end
endmodule // sdac_filter
`default_nettype wire

//--- rtl/sdac_control.v
// Purpose: register file, conversion sequencing, calibration and result correction
// Assumes: host serial transport is decoded elsewhere onto the register port
// Notes: conversion rate table covers 10 to 477 samples per second
`default_nettype none
`include "sdac_defs.vh"
// Behaviour
// - gain of one, two, four or eight is chosen by a two-bit field the host writes.
// - the gain is a digital scaling inside the filter path.
// - a status flag is set whenever a result passes the positive or negative range limit.
// - a single conversion waits four filter output periods before delivering a result.
// - continuous conversion rate is programmable from 10 to 477 samples per second.
// - unipolar and bipolar modes code the result differently.
// - zero and full-scale calibrations store coefficients that correct every result.
// - offset and gain coefficient registers are readable and writable by the host.
// - the offset coefficient may shift results positive to avoid unipolar clipping.
// - conversion-done can be routed to the interrupt pin or any user pin.
// - two ten-to-one selectors pick the positive and negative converter inputs.
// - the reference buffer is off after reset until the host enables it.
// - all configuration and readback pass over the host register port.
// - each selector has a four-bit field and a swap bit exchanges the two outputs.
// - after reset the ready interrupt source is unmasked and the interrupt is active high.
module sdac_control #(
  parameter WIDTH  = 16,
  parameter CLK_HZ = `SDAC_CLK_HZ
) (
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire [3:0]       addr_in,
  input  wire [15:0]      wdata_in,
  input  wire             write_in,
  input  wire             read_in,
  output reg  [15:0]      rdata_out,
  input  wire [WIDTH-1:0] raw_in,
  output reg              int_out,
  output reg  [3:0]       user_io_pin_out,
  output reg  [3:0]       mux_pos_out,
  output reg  [3:0]       mux_neg_out,
  output reg              refbuf_en_out,
  output reg              converting_out
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_SINGLE = 2'h1;
  localparam ST_CONT   = 2'h2;
  localparam ST_CAL    = 2'h3;

  reg [15:0] config_reg;
  reg [3:0]  positive_input_select;
  reg [3:0]  negative_input_select;
  reg [15:0] result;
  reg [2:0]  status;
  reg [2:0]  int_en;
  reg [15:0] offset_coef;
  reg [15:0] gain_coef;
  reg [2:0]  route;
  reg [1:0]  state;
  reg [2:0]  settle;
  reg        cal_full;
  reg        next_ready;
  reg        next_range;
  reg        next_caldone;
  reg [15:0] next_result;
  reg        irq_level;

  wire [1:0]  gain_select = config_reg[`SDAC_CFG_GAIN_LSB+1:`SDAC_CFG_GAIN_LSB];
  wire [2:0]  rate_sel    = config_reg[`SDAC_CFG_RATE_LSB+2:`SDAC_CFG_RATE_LSB];
  wire        bipolar     = config_reg[`SDAC_CFG_BIPOLAR];
  wire        input_swap_bit = config_reg[`SDAC_CFG_SWAP];
  wire        tick;
  wire [WIDTH+3:0] scaled;
  wire        cmd_wr      = write_in && addr_in == `SDAC_REG_CMD;

  // rates in samples per second; one entry per three-bit code
  function [31:0] rate_period;
    input [2:0] sel;
    reg   [31:0] sps;
    begin
      sps = 32'd10;
      case (sel)
        3'h0: sps = 32'd10;
        3'h1: sps = 32'd20;
        3'h2: sps = 32'd40;
        3'h3: sps = 32'd60;
        3'h4: sps = 32'd120;
        3'h5: sps = 32'd240;
        3'h6: sps = 32'd400;
        default: sps = 32'd477;
      endcase
      rate_period = CLK_HZ / sps;
    end
  endfunction

  // signed saturation to 16 bits
  function [15:0] sat16;
    input signed [35:0] v;
    begin
      if (v > 36'sh00007fff)
        sat16 = 16'h7fff;
      else if (v < -36'sh00008000)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  sdac_filter #(
    .WIDTH (WIDTH)
  ) u_filter (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .run_in     (state != ST_IDLE),
    .period_in  (rate_period(rate_sel)),
    .gain_in    (gain_select),
    .raw_in     (raw_in),
    .tick_out   (tick),
    .scaled_out (scaled)
  );

  // correction: subtract offset, scale by gain coefficient (0x8000 = unity)
  reg signed [19:0] corr_diff;
  reg signed [36:0] corr_prod;
  reg signed [35:0] corr_val;
  reg               over;
  always @*
  begin
    corr_diff = $signed(scaled) - $signed({{4{offset_coef[15]}}, offset_coef});
    corr_prod = corr_diff * $signed({1'b0, gain_coef});
    corr_val  = $signed(corr_prod[36:1]) >>> 14;
    over      = 1'b0;
    if (bipolar)
    begin
      next_result = sat16(corr_val);
      over = corr_val > 36'sh00007fff || corr_val < -36'sh00008000;
    end
    else if (corr_val < 36'sh0)
    begin
      next_result = 16'h0000;
      over = 1'b1;
    end
    else if (corr_val > 36'sh0000ffff)
    begin
      next_result = 16'hffff;
      over = 1'b1;
    end
    else
      next_result = corr_val[15:0];
  end

  // full-scale gain: unity times full code over the measured span
  wire [35:0] cal_quot = 36'h040000000 / {16'h0000, corr_diff};

  wire result_rd = read_in && addr_in == `SDAC_REG_RESULT;
  wire clr_wr    = write_in && addr_in == `SDAC_REG_INT_CLR;
  wire deliver   = tick && (state == ST_CONT || (state == ST_SINGLE && settle == 3'h0));

  // set beats clear for every sticky bit
  always @*
  begin
    next_ready   = status[`SDAC_ST_READY];
    next_range   = status[`SDAC_ST_RANGE];
    next_caldone = status[`SDAC_ST_CALDONE];
    if (result_rd || (clr_wr && wdata_in[`SDAC_ST_READY]))
      next_ready = 1'b0;
    if (clr_wr && wdata_in[`SDAC_ST_RANGE])
      next_range = 1'b0;
    if (clr_wr && wdata_in[`SDAC_ST_CALDONE])
      next_caldone = 1'b0;
    if (deliver)
    begin
      next_ready = 1'b1;
      if (over)
        next_range = 1'b1;
    end
    if (state == ST_CAL && tick && settle == 3'h0)
      next_caldone = 1'b1;
  end

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      config_reg            <= `SDAC_CFG_RESET;
      positive_input_select <= 4'h0;
      negative_input_select <= 4'h0;
      result                <= 16'h0000;
      status                <= 3'h0;
      int_en                <= `SDAC_INT_EN_RESET;
      offset_coef           <= `SDAC_OFFSET_RESET;
      gain_coef             <= `SDAC_GAIN_RESET;
      route                 <= 3'h0;
      state                 <= ST_IDLE;
      settle                <= 3'h0;
      cal_full              <= 1'b0;
      rdata_out             <= 16'h0000;
    end
    else
    begin
      status <= {next_caldone, next_range, next_ready};
      if (write_in)
      begin
        case (addr_in)
          `SDAC_REG_CONFIG: config_reg <= wdata_in;
          `SDAC_REG_MUX:
          begin
            positive_input_select <= wdata_in[3:0];
            negative_input_select <= wdata_in[7:4];
          end
          `SDAC_REG_INT_EN: int_en <= wdata_in[2:0];
          `SDAC_REG_OFFSET: offset_coef <= wdata_in;
          `SDAC_REG_GAIN:   gain_coef <= wdata_in;
          `SDAC_REG_ROUTE:  route <= wdata_in[2:0];
          default: ;
        endcase
      end
      rdata_out <= 16'h0000;
      if (read_in)
      begin
        case (addr_in)
          `SDAC_REG_CONFIG: rdata_out <= config_reg;
          `SDAC_REG_MUX:    rdata_out <= {8'h00, negative_input_select, positive_input_select};
          `SDAC_REG_RESULT: rdata_out <= result;
          `SDAC_REG_STATUS: rdata_out <= {13'h0, status};
          `SDAC_REG_INT_EN: rdata_out <= {13'h0, int_en};
          `SDAC_REG_OFFSET: rdata_out <= offset_coef;
          `SDAC_REG_GAIN:   rdata_out <= gain_coef;
          `SDAC_REG_ROUTE:  rdata_out <= {13'h0, route};
          default:          rdata_out <= 16'h0000;
        endcase
      end
      if (deliver)
        result <= next_result;
      case (state)
        ST_IDLE:
        begin
          settle <= `SDAC_SETTLE_PERIODS - 3'd1;
          if (cmd_wr && wdata_in[`SDAC_CMD_ZCAL])
          begin
            cal_full <= 1'b0;
            state    <= ST_CAL;
          end
          else if (cmd_wr && wdata_in[`SDAC_CMD_FCAL])
          begin
            cal_full <= 1'b1;
            state    <= ST_CAL;
          end
          else if (cmd_wr && wdata_in[`SDAC_CMD_START])
            state <= config_reg[`SDAC_CFG_CONT] ? ST_CONT : ST_SINGLE;
        end
        ST_SINGLE:
          if (cmd_wr && wdata_in[`SDAC_CMD_STOP])
            state <= ST_IDLE;
          else if (tick)
          begin
            if (settle == 3'h0)
              state <= ST_IDLE;
            else
              settle <= settle - 3'h1;
          end
        ST_CONT:
          if (cmd_wr && wdata_in[`SDAC_CMD_STOP])
            state <= ST_IDLE;
        ST_CAL:
          if (cmd_wr && wdata_in[`SDAC_CMD_STOP])
            state <= ST_IDLE;
          else if (tick)
          begin
            if (settle == 3'h0)
            begin
              // zero-scale stores the gain-scaled offset reading; full-scale sets gain so input hits full code
              if (!cal_full)
                offset_coef <= scaled[15:0];
              else if (corr_diff > 20'sh0)
                gain_coef <= (cal_quot > 36'h00000ffff) ? 16'hffff : cal_quot[15:0];
              state <= ST_IDLE;
            end
            else
              settle <= settle - 3'h1;
          end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // output stage: every pin from a flip-flop
  always @*
  begin
    irq_level = |(status & int_en);
  end

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      int_out         <= 1'b0;
      user_io_pin_out <= 4'h0;
      mux_pos_out     <= 4'h0;
      mux_neg_out     <= 4'h0;
      refbuf_en_out   <= 1'b0;
      converting_out  <= 1'b0;
    end
    else
    begin
      // ready routes to a user pin instead of the interrupt when a pin is chosen
      int_out <= (route == 3'h0 ? irq_level : |(status[2:1] & int_en[2:1]))
                 ^ config_reg[`SDAC_CFG_INT_POL];
      user_io_pin_out <= 4'h0;
      if (route != 3'h0 && route <= 3'h4)
        user_io_pin_out[route[1:0] - 2'h1] <= status[`SDAC_ST_READY];
      mux_pos_out    <= input_swap_bit ? negative_input_select : positive_input_select;
      mux_neg_out    <= input_swap_bit ? positive_input_select : negative_input_select;
      refbuf_en_out  <= config_reg[`SDAC_CFG_REFBUF];
      converting_out <= state != ST_IDLE;
    end
  end
endmodule // sdac_control
`default_nettype wire

//--- testbench/sdac_control_props.sv
// Purpose: port-level checker for the converter control block
// Assumes: register writes settle on the outputs within three cycles
// Notes: shadows of written registers stand in for the hidden state
`default_nettype none
`include "sdac_defs.vh"
module sdac_control_props #(
  parameter WIDTH = 16
) (
  input wire logic             clock_in,
  input wire logic             rst_in,
  input wire logic [3:0]       addr_in,
  input wire logic [15:0]      wdata_in,
  input wire logic             write_in,
  input wire logic             read_in,
  input wire logic [15:0]      rdata_out,
  input wire logic [WIDTH-1:0] raw_in,
  input wire logic             int_out,
  input wire logic [3:0]       user_io_pin_out,
  input wire logic [3:0]       mux_pos_out,
  input wire logic [3:0]       mux_neg_out,
  input wire logic             refbuf_en_out,
  input wire logic             converting_out
);
  logic [15:0] cfg_q;
  logic [15:0] mux_q;
  logic [15:0] ien_q;
  logic [15:0] route_q;
  logic [1:0]  age;
  logic [3:0]  mask;
  always @*
  begin
    mask = (route_q >= 16'h1 && route_q <= 16'h4) ? (4'h1 << (route_q[1:0] - 2'h1)) : 4'h0;
  end
  // any write restarts the settle count, so stale shadows are never judged
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      cfg_q <= `SDAC_CFG_RESET;
      mux_q <= 16'h0000;
      ien_q <= {13'h0000, `SDAC_INT_EN_RESET};
      route_q <= 16'h0000;
      age <= 2'h3;
    end
    else
    begin
      if (write_in && addr_in == `SDAC_REG_CONFIG) cfg_q <= wdata_in;
      if (write_in && addr_in == `SDAC_REG_MUX) mux_q <= wdata_in;
      if (write_in && addr_in == `SDAC_REG_INT_EN) ien_q <= wdata_in;
      if (write_in && addr_in == `SDAC_REG_ROUTE) route_q <= wdata_in;
      age <= write_in ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
    end
  end
  rdata_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !$past(read_in) |-> rdata_out == 16'h0000) else $error("read data outside read slot");
  unmapped_read_a: assert property (@(posedge clock_in) disable iff (rst_in)
    read_in && addr_in > 4'h9 |=> rdata_out == 16'h0000) else $error("unmapped read not zero");
  reset_quiet_a: assert property (@(posedge clock_in) rst_in |=> int_out == 1'b0
    && refbuf_en_out == 1'b0 && converting_out == 1'b0 && user_io_pin_out == 4'h0)
    else $error("outputs active after reset");
  refbuf_follow_a: assert property (@(posedge clock_in) disable iff (rst_in)
    age == 2'h3 |-> refbuf_en_out == cfg_q[8]) else $error("reference buffer enable wrong");
  mux_order_a: assert property (@(posedge clock_in) disable iff (rst_in)
    age == 2'h3 |-> {mux_neg_out, mux_pos_out} == (cfg_q[7] ? {mux_q[3:0], mux_q[7:4]}
    : mux_q[7:0])) else $error("selector outputs wrong");
  int_masked_a: assert property (@(posedge clock_in) disable iff (rst_in)
    age == 2'h3 && ien_q[2:0] == 3'h0 |-> int_out == cfg_q[9]) else $error("masked interrupt");
  ready_rerouted_a: assert property (@(posedge clock_in) disable iff (rst_in)
    age == 2'h3 && ien_q[2:0] == 3'h1 && mask != 4'h0 |-> int_out == cfg_q[9])
    else $error("rerouted ready still on interrupt");
  user_pin_a: assert property (@(posedge clock_in) disable iff (rst_in)
    age == 2'h3 |-> (user_io_pin_out & ~mask) == 4'h0) else $error("wrong user pin driven");
  start_busy_a: assert property (@(posedge clock_in) disable iff (rst_in)
    write_in && addr_in == `SDAC_REG_CMD && wdata_in[0] |-> ##[1:3] converting_out)
    else $error("start did not begin conversion");
  stop_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
    write_in && addr_in == `SDAC_REG_CMD && wdata_in[3] && !wdata_in[0] |-> ##[1:3]
    !converting_out) else $error("stop did not end conversion");
endmodule // sdac_control_props
bind sdac_control sdac_control_props #(.WIDTH(WIDTH)) sdac_control_props_i (
  .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .raw_in(raw_in),
  .int_out(int_out), .user_io_pin_out(user_io_pin_out), .mux_pos_out(mux_pos_out),
  .mux_neg_out(mux_neg_out), .refbuf_en_out(refbuf_en_out),
  .converting_out(converting_out));
`default_nettype wire

//--- testbench/sdac_host.sv
// Purpose: host model driving the register port
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes: tasks are called hierarchically by the bench
`default_nettype none
module sdac_host (
  input  wire logic        clock_in,
  input  wire logic [15:0] rdata_in,
  output var  logic [3:0]  addr_out,
  output var  logic [15:0] wdata_out,
  output var  logic        write_out,
  output var  logic        read_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr_out = 4'h0;
    wdata_out = 16'h0000;
    write_out = 1'b0;
    read_out = 1'b0;
  end
  // all configuration goes through this port
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clock_in);
    write_out <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just past the edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge clock_in);
    read_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // sdac_host
`default_nettype wire

//--- testbench/sdac_control_test.sv
// Purpose: register-level test of the converter control block
// Assumes: converter clock scaled down so a rate-7 period lasts 1000 cycles
// Notes: results judged with unity gain coefficient or at saturation
`default_nettype none
`include "sdac_defs.vh"
module sdac_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // short rate periods keep the run well inside the cycle budget
  localparam int SIM_HZ = 477000;
  localparam int RATE_P = SIM_HZ / 477;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] raw = 16'h0000;
  wire  [3:0]  addr;
  wire  [15:0] wdata;
  wire         wr_s;
  wire         rd_s;
  wire  [15:0] rdata;
  wire         int_o;
  wire  [3:0]  user_io_pin;
  wire  [3:0]  mpos;
  wire  [3:0]  mneg;
  wire         refbuf;
  wire         conv;
  int          miscompares = 0;
  int          compares = 0;
  int          n;
  logic [3:0]  i;
  always #10 clock_in = ~clock_in;
  sdac_host sdac_host_i (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .write_out(wr_s), .read_out(rd_s));
  sdac_control #(.CLK_HZ(SIM_HZ)) sdac_control_i (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .write_in(wr_s), .read_in(rd_s), .rdata_out(rdata),
    .raw_in(raw), .int_out(int_o), .user_io_pin_out(user_io_pin), .mux_pos_out(mpos),
    .mux_neg_out(mneg), .refbuf_en_out(refbuf), .converting_out(conv));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    sdac_host_i.rd(a, d);
    check(d, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the first result needs filter settling, hence the generous bound
  task automatic wait_int(input int lim, output int cnt);
    cnt = 0;
    while (int_o !== 1'b1 && cnt < lim)
    begin
      @(posedge clock_in);
      #1;
      cnt++;
    end
    if (int_o !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    rchk(`SDAC_REG_CONFIG, `SDAC_CFG_RESET);
    rchk(`SDAC_REG_INT_EN, 16'h0001);
    rchk(`SDAC_REG_OFFSET, `SDAC_OFFSET_RESET);
    rchk(`SDAC_REG_GAIN, `SDAC_GAIN_RESET);
    rchk(`SDAC_REG_STATUS, 16'h0000);
    check({15'h0, refbuf}, 16'h0000);
    check({15'h0, int_o}, 16'h0000);
    sdac_host_i.wr(`SDAC_REG_OFFSET, 16'h0100);
    sdac_host_i.wr(`SDAC_REG_GAIN, 16'h9abc);
    rchk(`SDAC_REG_OFFSET, 16'h0100);
    rchk(`SDAC_REG_GAIN, 16'h9abc);
    sdac_host_i.wr(4'hf, 16'hffff);
    rchk(4'hf, 16'h0000);
    for (i = 4'h0; i <= 4'h9; i++)
    begin
      sdac_host_i.wr(`SDAC_REG_MUX, {8'h00, 4'h9 - i, i});
      settle();
      check({8'h00, mneg, mpos}, {8'h00, 4'h9 - i, i});
    end
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h0080);
    settle();
    check({8'h00, mneg, mpos}, 16'h0090);
    for (i = 4'h0; i <= 4'h7; i++)
    begin
      sdac_host_i.wr(`SDAC_REG_CONFIG, {7'h00, 1'b1, 3'h0, i[1:0], i[2:0]});
      rchk(`SDAC_REG_CONFIG, {7'h00, 1'b1, 3'h0, i[1:0], i[2:0]});
      check({15'h0, refbuf}, 16'h0001);
    end
    sdac_host_i.wr(`SDAC_REG_GAIN, 16'h8000);
    @(posedge clock_in) raw <= 16'h1000;
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h0117);
    sdac_host_i.wr(`SDAC_REG_CMD, 16'h0001);
    wait_int(5 * RATE_P, n);
    check({15'h0, n >= 4 * RATE_P && n <= 4 * RATE_P + 8}, 16'h0001);
    rchk(`SDAC_REG_RESULT, 16'h3f00);
    check({15'h0, conv}, 16'h0000);
    // negative offset lifts a slightly negative unipolar input off zero
    sdac_host_i.wr(`SDAC_REG_OFFSET, 16'hff00);
    @(posedge clock_in) raw <= 16'hfff0;
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h0107);
    sdac_host_i.wr(`SDAC_REG_CMD, 16'h0001);
    wait_int(5 * RATE_P, n);
    rchk(`SDAC_REG_RESULT, 16'h00f0);
    rchk(`SDAC_REG_STATUS, 16'h0000);
    // full-scale input at gain eight must overrange
    @(posedge clock_in) raw <= 16'h7fff;
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h007f);
    sdac_host_i.wr(`SDAC_REG_CMD, 16'h0001);
    wait_int(2 * RATE_P, n);
    check({15'h0, n >= RATE_P && n <= RATE_P + 8}, 16'h0001);
    check({15'h0, conv}, 16'h0001);
    rchk(`SDAC_REG_STATUS, 16'h0003);
    sdac_host_i.wr(`SDAC_REG_INT_EN, 16'h0000);
    settle();
    check({15'h0, int_o}, 16'h0000);
    sdac_host_i.wr(`SDAC_REG_INT_EN, 16'h0001);
    settle();
    check({15'h0, int_o}, 16'h0001);
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h027f);
    settle();
    check({15'h0, int_o}, 16'h0000);
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h007f);
    for (i = 4'h1; i <= 4'h4; i++)
    begin
      sdac_host_i.wr(`SDAC_REG_ROUTE, {12'h000, i});
      settle();
      check({11'h0, int_o, user_io_pin}, {12'h000, 4'h1 << (i - 4'h1)});
    end
    sdac_host_i.wr(`SDAC_REG_ROUTE, 16'h0000);
    settle();
    check({11'h0, int_o, user_io_pin}, 16'h0010);
    rchk(`SDAC_REG_RESULT, 16'h7fff);
    rchk(`SDAC_REG_STATUS, 16'h0002);
    settle();
    check({15'h0, int_o}, 16'h0000);
    sdac_host_i.wr(`SDAC_REG_INT_CLR, 16'h0002);
    rchk(`SDAC_REG_STATUS, 16'h0000);
    sdac_host_i.wr(`SDAC_REG_CMD, 16'h0008);
    settle();
    check({15'h0, conv}, 16'h0000);
    // recalibrate after the configuration change, caldone drives the interrupt
    sdac_host_i.wr(`SDAC_REG_CONFIG, 16'h0107);
    sdac_host_i.wr(`SDAC_REG_INT_EN, 16'h0004);
    @(posedge clock_in) raw <= 16'h0010;
    sdac_host_i.wr(`SDAC_REG_CMD, 16'h0002);
    wait_int(5 * RATE_P, n);
    rchk(`SDAC_REG_OFFSET, 16'h0010);
    sdac_host_i.wr(`SDAC_REG_INT_CLR, 16'h0004);
    @(posedge clock_in) raw <= 16'h7fff;
    sdac_host_i.wr(`SDAC_REG_CMD, 16'h0004);
    wait_int(5 * RATE_P, n);
    rchk(`SDAC_REG_GAIN, 16'h8011);
    complete_run();
  end
endmodule // sdac_control_test
`default_nettype wire
